// ===== rtl/desc_if.sv
// decoded view of one transmit control word
// assumes one engine and one decoder on the same clock

`timescale 1ns/1ps

interface desc_if;
    logic [31:0]                  ctl;
    logic [tx_desc_pkg::LEN_W-1:0] len;
    logic                         last;
    logic                         eor;
    logic                         irq;
    tx_desc_pkg::fwd_mode_t       mode;
    logic [1:0]                   ports;

    modport decoder (input ctl, output len, last, eor, irq, mode, ports);
    modport engine  (output ctl, input len, last, eor, irq, mode, ports);
endinterface : desc_if

// ===== rtl/tx_ctl_decode.sv
// field decoder for the second descriptor word
// assumes the word is stable while the engine reads the fields

`timescale 1ns/1ps

module tx_ctl_decode (
    desc_if.decoder d
);
    logic [1:0] map;

    always_comb begin
        // reserved bits 23:22 and 19:11 are never looked at
        map     = d.ctl[tx_desc_pkg::MAP_HI:tx_desc_pkg::MAP_LO];
        d.len   = d.ctl[tx_desc_pkg::LEN_W-1:0];
        d.last  = d.ctl[tx_desc_pkg::LAST_BIT];
        d.eor   = d.ctl[tx_desc_pkg::EOR_BIT];
        d.irq   = d.ctl[tx_desc_pkg::IRQ_BIT] & d.ctl[tx_desc_pkg::LAST_BIT];
        d.ports = map;
        if (!d.ctl[tx_desc_pkg::LAST_BIT]) begin
            d.mode = tx_desc_pkg::FWD_LOOKUP;
        end else if (map == 2'h3) begin
            d.mode = tx_desc_pkg::FWD_BCAST;
        end else if (map == 2'h0) begin
            d.mode = tx_desc_pkg::FWD_LOOKUP;
        end else begin
            d.mode = tx_desc_pkg::FWD_FORCED;
        end
    end
endmodule : tx_ctl_decode

// ===== rtl/tx_desc_engine.sv
// transmit descriptor engine with an AXI4-Lite register slave
// assumes memory, buffer mover and MAC all run on CLOCK_I

`timescale 1ns/1ps

module tx_desc_engine #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              CLOCK_I,
    input  wire logic              RST_I,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0] AWADDR_I,
    input  wire logic              AWVALID_I,
    output logic                   AWREADY_O,
    input  wire logic [31:0]       WDATA_I,
    input  wire logic [3:0]        WSTRB_I,
    input  wire logic              WVALID_I,
    output logic                   WREADY_O,
    output logic [1:0]             BRESP_O,
    output logic                   BVALID_O,
    input  wire logic              BREADY_I,
    input  wire logic [ADDR_W-1:0] ARADDR_I,
    input  wire logic              ARVALID_I,
    output logic                   ARREADY_O,
    output logic [31:0]            RDATA_O,
    output logic [1:0]             RRESP_O,
    output logic                   RVALID_O,
    input  wire logic              RREADY_I,
    // descriptor memory port
    output logic                   MEM_REQ_O,
    output logic                   MEM_WE_O,
    output logic [31:0]            MEM_ADDR_O,
    output logic [31:0]            MEM_WDATA_O,
    input  wire logic              MEM_ACK_I,
    input  wire logic [31:0]       MEM_RDATA_I,
    // buffer fetch port
    output logic                   BUF_REQ_O,
    output logic [31:0]            BUF_ADDR_O,
    output logic [10:0]            BUF_LEN_O,
    input  wire logic              BUF_DONE_I,
    // frame forwarding
    output logic                   FWD_VALID_O,
    output logic [1:0]             FWD_MODE_O,
    output logic [1:0]             FWD_PORTS_O,
    input  wire logic              TX_DONE_I,
    // interrupt
    output logic                   IRQ_O
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        tx_desc_pkg::eng_state_t     state;
        logic [1:0]                  idx;
        logic [3:0][31:0]            words;
        logic [31:0]                 base;
        logic [31:0]                 cur;
        logic                        enable;
        logic                        pend;
        logic [tx_desc_pkg::ST_W-1:0] status;
        logic [tx_desc_pkg::ST_W-1:0] mask;
        logic                        irq;
        logic                        aw_got;
        logic                        w_got;
        logic [ADDR_W-1:0]           aw_addr;
        logic [31:0]                 wdata;
        logic [3:0]                  wstrb;
        logic                        awready;
        logic                        wready;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        arready;
        logic                        rvalid;
        logic [31:0]                 rdata;
        logic [1:0]                  rresp;
        logic                        mem_req;
        logic                        mem_we;
        logic [31:0]                 mem_addr;
        logic [31:0]                 mem_wdata;
        logic                        buf_req;
        logic [31:0]                 buf_addr;
        logic [10:0]                 buf_len;
        logic                        fwd_valid;
        logic [1:0]                  fwd_mode;
        logic [1:0]                  fwd_ports;
    } eng_t;

    eng_t st;
    eng_t next_st;

    desc_if dif ();

    tx_ctl_decode u_decode (
        .d (dif.decoder)
    );

    assign dif.ctl = st.words[1];

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = val[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic [ADDR_W-1:0]            wa;
        logic [ADDR_W-1:0]            ra;
        logic [31:0]                  wv;
        logic [tx_desc_pkg::ST_W-1:0] set_ev;
        logic [tx_desc_pkg::ST_W-1:0] clr_ev;
        wa      = {st.aw_addr[ADDR_W-1:2], 2'h0};
        ra      = {ARADDR_I[ADDR_W-1:2], 2'h0};
        wv      = 32'h0000_0000;
        set_ev  = '0;
        clr_ev  = '0;
        next_st = st;
        next_st.fwd_valid = 1'b0;

        // axi write channels, taken in either order
        if (AWVALID_I && st.awready) begin
            next_st.aw_got  = 1'b1;
            next_st.aw_addr = AWADDR_I;
        end
        if (WVALID_I && st.wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = WDATA_I;
            next_st.wstrb = WSTRB_I;
        end
        if (st.bvalid && BREADY_I) begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_got && st.w_got && !st.bvalid) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = tx_desc_pkg::RESP_OK;
            wv = merge(32'h0000_0000, st.wdata, st.wstrb);
            if (wa == tx_desc_pkg::OFS_CTRL) begin
                next_st.enable = st.wstrb[0] ? wv[tx_desc_pkg::CTRL_EN] : st.enable;
                if (wv[tx_desc_pkg::CTRL_KICK]) begin
                    next_st.pend = 1'b1;
                end
            end else if (wa == tx_desc_pkg::OFS_BASE) begin
                next_st.base = merge(st.base, st.wdata, st.wstrb);
                next_st.cur  = merge(st.base, st.wdata, st.wstrb); // a new base also moves the current pointer to it
            end else if (wa == tx_desc_pkg::OFS_STATUS) begin
                clr_ev = wv[tx_desc_pkg::ST_W-1:0];
            end else if (wa == tx_desc_pkg::OFS_MASK) begin
                next_st.mask = st.wstrb[0] ? wv[tx_desc_pkg::ST_W-1:0] : st.mask;
            end else if (wa == tx_desc_pkg::OFS_CUR || wa == tx_desc_pkg::OFS_INFO) begin
                next_st.bresp = tx_desc_pkg::RESP_OK;
            end else begin
                next_st.bresp = tx_desc_pkg::RESP_ERR;
            end
        end
        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready  = !next_st.w_got && !next_st.bvalid;

        // axi read channel
        if (st.rvalid && RREADY_I) begin
            next_st.rvalid = 1'b0;
        end
        if (ARVALID_I && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = tx_desc_pkg::RESP_OK;
            if (ra == tx_desc_pkg::OFS_CTRL) begin
                next_st.rdata = {31'h0, st.enable};
            end else if (ra == tx_desc_pkg::OFS_BASE) begin
                next_st.rdata = st.base;
            end else if (ra == tx_desc_pkg::OFS_STATUS) begin
                next_st.rdata = {30'h0, st.status};
            end else if (ra == tx_desc_pkg::OFS_MASK) begin
                next_st.rdata = {30'h0, st.mask};
            end else if (ra == tx_desc_pkg::OFS_CUR) begin
                next_st.rdata = st.cur;
            end else if (ra == tx_desc_pkg::OFS_INFO) begin
                next_st.rdata = {25'h0, st.state, st.fwd_mode, st.fwd_ports};
            end else begin
                next_st.rdata = 32'h0000_0000;
                next_st.rresp = tx_desc_pkg::RESP_ERR;
            end
        end
        next_st.arready = !next_st.rvalid;

        // ************************************************************
        // descriptor walk
        // ************************************************************
        case (st.state)
            tx_desc_pkg::S_IDLE: begin
                if (st.enable && st.pend) begin
                    next_st.pend     = 1'b0;
                    next_st.idx      = 2'h0;
                    next_st.mem_req  = 1'b1;
                    next_st.mem_we   = 1'b0;
                    next_st.mem_addr = st.cur;
                    next_st.state    = tx_desc_pkg::S_FETCH;
                end
            end
            tx_desc_pkg::S_FETCH: begin
                if (MEM_ACK_I) begin
                    next_st.words[st.idx] = MEM_RDATA_I;
                    if (st.idx == 2'h0 && !MEM_RDATA_I[tx_desc_pkg::OWN_BIT]) begin
                        next_st.mem_req = 1'b0; // host still owns it: park until the next kick
                        set_ev[tx_desc_pkg::ST_UNAVAIL] = 1'b1;
                        next_st.state = tx_desc_pkg::S_IDLE;
                    end else if (st.idx == 2'(tx_desc_pkg::WORDS - 1)) begin
                        next_st.mem_req = 1'b0;
                        next_st.state   = tx_desc_pkg::S_CHECK;
                    end else begin
                        next_st.idx      = st.idx + 2'h1;
                        next_st.mem_addr = st.mem_addr + 32'(tx_desc_pkg::WORD_BYTES);
                    end
                end
            end
            tx_desc_pkg::S_CHECK: begin
                if (dif.len != 11'h000) begin
                    next_st.buf_req  = 1'b1;
                    next_st.buf_addr = st.words[2];
                    next_st.buf_len  = dif.len;
                    next_st.state    = tx_desc_pkg::S_BUF;
                end else begin
                    next_st.state = tx_desc_pkg::S_END;
                end
            end
            tx_desc_pkg::S_BUF: begin
                if (BUF_DONE_I) begin
                    next_st.buf_req = 1'b0;
                    next_st.state   = tx_desc_pkg::S_END;
                end
            end
            tx_desc_pkg::S_END: begin
                if (dif.last) begin
                    next_st.fwd_valid = 1'b1;
                    next_st.fwd_mode  = dif.mode;
                    next_st.fwd_ports = dif.ports;
                    next_st.state     = tx_desc_pkg::S_WAIT_TX;
                end else begin
                    next_st.state = tx_desc_pkg::S_WB;
                end
            end
            tx_desc_pkg::S_WAIT_TX: begin
                if (TX_DONE_I) begin
                    set_ev[tx_desc_pkg::ST_DONE] = dif.irq;
                    next_st.state = tx_desc_pkg::S_WB;
                end
            end
            tx_desc_pkg::S_WB: begin
                next_st.mem_req   = 1'b1;
                next_st.mem_we    = 1'b1;
                next_st.mem_addr  = st.cur;
                next_st.mem_wdata = st.words[0] & ~(32'h1 << tx_desc_pkg::OWN_BIT);
                next_st.state     = tx_desc_pkg::S_WB_WAIT;
            end
            tx_desc_pkg::S_WB_WAIT: begin
                if (MEM_ACK_I) begin
                    next_st.mem_req = 1'b0;
                    next_st.mem_we  = 1'b0;
                    // next pointer used as is; host keeps it word aligned
                    next_st.cur     = dif.eor ? st.base : st.words[3];
                    next_st.pend    = 1'b1;
                    next_st.state   = tx_desc_pkg::S_IDLE;
                end
            end
            default: begin
                next_st.state = tx_desc_pkg::S_IDLE;
            end
        endcase

        // set wins over a same-cycle clear
        next_st.status = (st.status & ~clr_ev) | set_ev;
        next_st.irq    = |(next_st.status & next_st.mask);
    end

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            st         <= '0;
            st.state   <= tx_desc_pkg::S_IDLE;
            st.base    <= tx_desc_pkg::RST_WORD;
            st.cur     <= tx_desc_pkg::RST_WORD;
            st.awready <= 1'b1;
            st.wready  <= 1'b1;
            st.arready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign AWREADY_O   = st.awready;
    assign WREADY_O    = st.wready;
    assign BRESP_O     = st.bresp;
    assign BVALID_O    = st.bvalid;
    assign ARREADY_O   = st.arready;
    assign RDATA_O     = st.rdata;
    assign RRESP_O     = st.rresp;
    assign RVALID_O    = st.rvalid;
    assign MEM_REQ_O   = st.mem_req;
    assign MEM_WE_O    = st.mem_we;
    assign MEM_ADDR_O  = st.mem_addr;
    assign MEM_WDATA_O = st.mem_wdata;
    assign BUF_REQ_O   = st.buf_req;
    assign BUF_ADDR_O  = st.buf_addr;
    assign BUF_LEN_O   = st.buf_len;
    assign FWD_VALID_O = st.fwd_valid;
    assign FWD_MODE_O  = st.fwd_mode;
    assign FWD_PORTS_O = st.fwd_ports;
    assign IRQ_O       = st.irq;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);

    a_forced_port_bits: assert property (
        FWD_VALID_O && FWD_MODE_O == 2'(tx_desc_pkg::FWD_FORCED) |-> FWD_PORTS_O == st.words[1][21:20]
    ) else $error("forced ports differ from map bits");
    a_all_ones_bcast: assert property (
        FWD_VALID_O && st.words[1][21:20] == 2'h3 |-> FWD_MODE_O == 2'(tx_desc_pkg::FWD_BCAST)
    ) else $error("full map did not broadcast");
    a_zero_map_lookup: assert property (
        FWD_VALID_O && st.words[1][21:20] == 2'h0 |-> FWD_MODE_O == 2'(tx_desc_pkg::FWD_LOOKUP)
    ) else $error("zero map not sent to lookup");
    a_map_last_only: assert property (
        FWD_VALID_O |-> st.words[1][29] ##1 !FWD_VALID_O
    ) else $error("map used outside last segment");
    a_reserved_ignored: assert property (
        FWD_VALID_O && st.words[1][21:20] == 2'h1 |-> FWD_MODE_O == 2'(tx_desc_pkg::FWD_FORCED) && FWD_PORTS_O == 2'h1
    ) else $error("reserved map bits changed forwarding");
    a_length_exact: assert property (
        $rose(BUF_REQ_O) |-> BUF_LEN_O == st.words[1][10:0] && BUF_LEN_O != 11'h000
    ) else $error("buffer length mismatch");
    a_zero_skip: assert property (
        st.state == tx_desc_pkg::S_CHECK && st.words[1][10:0] == 11'h000 |=> !BUF_REQ_O [*2]
    ) else $error("zero length buffer fetched");
    a_buffer_addr: assert property (
        BUF_REQ_O |-> BUF_ADDR_O == st.words[2]
    ) else $error("buffer address not word three");
    a_next_pointer: assert property (
        st.state == tx_desc_pkg::S_WB_WAIT && MEM_ACK_I && !st.words[1][25] |=> st.cur == $past(st.words[3])
    ) else $error("next descriptor pointer wrong");
    a_owner_cleared: assert property (
        MEM_REQ_O && MEM_WE_O |-> !MEM_WDATA_O[31] && MEM_ADDR_O == st.cur
    ) else $error("writeback keeps ownership");
    a_ring_wrap: assert property (
        st.state == tx_desc_pkg::S_WB_WAIT && MEM_ACK_I && st.words[1][25] |=> st.cur == st.base
    ) else $error("end of ring did not wrap");
    a_done_irq: assert property (
        st.state == tx_desc_pkg::S_WAIT_TX && TX_DONE_I && st.words[1][31] |=> st.status[0] && (IRQ_O || !st.mask[0])
    ) else $error("completion status not raised");
    a_fetch_first: assert property (
        $rose(BUF_REQ_O) |-> $past(st.state) == tx_desc_pkg::S_CHECK && $past(st.idx, 2) == 2'h3
    ) else $error("buffer read before descriptor fetched");

endmodule : tx_desc_engine

// ===== rtl/tx_desc_pkg.sv
// Contract
// - Port map bits 20 and 21 of the control word force output port one and port two.
// - A port map with every port bit set broadcasts the frame to all ports.
// - A port map of all zeros is ignored and the internal address lookup forwards the frame.
// - The port map is honoured only in a last-segment descriptor and disregarded elsewhere.
// - Port map bits 23 and 22 are reserved, never acted on, and kept at zero by the host.
// - The buffer length is the eleven-bit byte count in bits 10 to 0, and exactly that many bytes are fetched.
// - A zero buffer length skips the buffer with no data fetch and moves on.
// - The third word is a 32-bit buffer address of any byte alignment.
// - The fourth word is the 32-bit address of the next descriptor.
// - Ownership is cleared when the frame is sent or the buffer emptied; the host sets the first owner bit last.
// - Control word bit 29 marks the last segment of a frame.
// - With bit 25 set the next fetch comes from the list base address.
// - With bit 31 set in a last segment the transmit interrupt is raised after transmission.
//
// shared constants and types of the transmit descriptor engine
// assumes a 32-bit byte-addressed host memory port

package tx_desc_pkg;

    // ************************************************************
    // descriptor layout
    // ************************************************************
    localparam int OWN_BIT      = 31;
    localparam int IRQ_BIT      = 31;
    localparam int LAST_BIT     = 29;
    localparam int EOR_BIT      = 25;
    localparam int MAP_LO       = 20;
    localparam int MAP_HI       = 21;
    localparam int LEN_W        = 11;
    localparam int WORDS        = 4;
    localparam int WORD_BYTES   = 4;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_BASE   = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_MASK   = 8'h0C;
    localparam logic [7:0] OFS_CUR    = 8'h10;
    localparam logic [7:0] OFS_INFO   = 8'h14;
    localparam int CTRL_EN      = 0;
    localparam int CTRL_KICK    = 1;
    localparam int ST_W         = 2;
    localparam int ST_DONE      = 0;
    localparam int ST_UNAVAIL   = 1;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0]  RESP_OK  = 2'h0;
    localparam logic [1:0]  RESP_ERR = 2'h2;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {FWD_LOOKUP, FWD_FORCED, FWD_BCAST} fwd_mode_t;
    typedef enum logic [2:0] {S_IDLE, S_FETCH, S_CHECK, S_BUF, S_END, S_WAIT_TX, S_WB, S_WB_WAIT} eng_state_t;

endpackage : tx_desc_pkg

// ===== sim/tx_descriptor_interpreter_tb_top.sv
// bench for the transmit descriptor engine
// assumes tx_host_model on the memory, buffer and mac side
`timescale 1ns/1ps
module tx_descriptor_interpreter_tb_top;
    // ****
    // bench
    // ****
    typedef struct packed {logic [31:0] ctl; logic [3:0] fwd;} row_t;
    logic        clk, rst, slow, awv, wv, bre, arv, rre, awr, wrdy, bv, arr, rv, mreq, mwe, mack, breq, bdone, fv, txd, irq;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rdat, maddr, mwd, mrd, baddr, d;
    logic [1:0]  bresp, rresp, fmode, fports, r;
    logic [10:0] blen;
    logic [42:0] bq[$];
    logic [3:0]  fq[$];
    int          fail_count, total_checks;
    row_t rows [6] = '{'{32'h2010_0004, 4'h5}, '{32'h2020_0005, 4'h6}, '{32'hA030_0006, 4'hB},
                       '{32'h2000_F807, 4'h0}, '{32'h20C0_07FF, 4'h0}, '{32'h2070_0000, 4'hB}};
    tx_desc_engine tx_desc_engine_inst (.CLOCK_I(clk), .RST_I(rst), .AWADDR_I(awa), .AWVALID_I(awv),
        .AWREADY_O(awr), .WDATA_I(wd), .WSTRB_I(4'hF), .WVALID_I(wv), .WREADY_O(wrdy), .BRESP_O(bresp),
        .BVALID_O(bv), .BREADY_I(bre), .ARADDR_I(ara), .ARVALID_I(arv), .ARREADY_O(arr), .RDATA_O(rdat),
        .RRESP_O(rresp), .RVALID_O(rv), .RREADY_I(rre), .MEM_REQ_O(mreq), .MEM_WE_O(mwe), .MEM_ADDR_O(maddr),
        .MEM_WDATA_O(mwd), .MEM_ACK_I(mack), .MEM_RDATA_I(mrd), .BUF_REQ_O(breq), .BUF_ADDR_O(baddr),
        .BUF_LEN_O(blen), .BUF_DONE_I(bdone), .FWD_VALID_O(fv), .FWD_MODE_O(fmode), .FWD_PORTS_O(fports),
        .TX_DONE_I(txd), .IRQ_O(irq));
    tx_host_model tx_host_model_inst (.clk_i(clk), .rst_i(rst), .slow_i(slow), .mem_req_i(mreq), .mem_we_i(mwe),
        .mem_addr_i(maddr), .mem_wdata_i(mwd), .buf_req_i(breq), .fwd_valid_i(fv), .mem_ack_o(mack),
        .mem_rdata_o(mrd), .buf_done_o(bdone), .tx_done_o(txd));
    always #5 clk = ~clk;
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s: got %0h expected %0h", $time, what, got, exp);
        end
    endtask : chk
    always @(posedge clk) begin
        if (fv === 1'b1) chk({fmode, fports}, fq.size() > 0 ? fq.pop_front() : 'x, "fwd");
        if (bdone === 1'b1) chk({baddr, blen}, bq.size() > 0 ? bq.pop_front() : 'x, "buf");
    end
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
        for (int n = 0; n < 99 && !(bv && bre); n++) begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end
        chk(bv, 1'b1, "write answer");
        r = bresp; bre <= 1'b0;
    endtask : axw
    task automatic axr(input logic [7:0] a);
        @(posedge clk);
        ara <= a; arv <= 1'b1; rre <= 1'b1;
        for (int n = 0; n < 99 && !(rv && rre); n++) begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end
        chk(rv, 1'b1, "read answer");
        d = rdat; r = rresp; rre <= 1'b0;
    endtask : axr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        axr(a);
        chk({r, d}, {tx_desc_pkg::RESP_OK, e}, "reg read");
    endtask : rdc
    task automatic put(input int i, input logic [31:0] v);
        tx_host_model_inst.mem[i] = v;
    endtask : put
    task automatic run(input logic [1:0] st, input logic [31:0] cur);
        axw(tx_desc_pkg::OFS_BASE, 32'h0);
        axw(tx_desc_pkg::OFS_CTRL, 32'h3);
        for (int n = 0; n < 900 && irq !== 1'b1; n++) @(posedge clk);
        chk(irq, 1'b1, "irq raised");
        chk(bq.size() + fq.size(), 0, "left over");
        rdc(tx_desc_pkg::OFS_STATUS, {30'h0, st});
        rdc(tx_desc_pkg::OFS_CUR, cur);
        axw(tx_desc_pkg::OFS_STATUS, 32'h3);
        @(posedge clk);
        chk(irq, 0, "irq clear");
        $display("test done at %0t", $time);
    endtask : run
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    initial begin
        clk = 0; rst = 1; slow = 0; awv = 0; wv = 0; bre = 0; arv = 0; rre = 0; awa = 0; ara = 0; wd = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) rdc(8'(4 * i), tx_desc_pkg::RST_WORD);
        axw(8'h18, 32'h1);
        chk(r, tx_desc_pkg::RESP_ERR, "wr unmapped");
        axr(8'h18);
        chk({r, d}, {tx_desc_pkg::RESP_ERR, 32'h0}, "rd unmapped");
        $display("reset and map test done at %0t", $time);
        axw(tx_desc_pkg::OFS_MASK, 32'h2);
        foreach (rows[i]) begin
            put(1, rows[i].ctl); put(2, 32'h1001 + 32'(i)); put(3, 32'h10); put(4, 32'h0);
            put(0, 32'h8000_0000);
            if (rows[i].ctl[10:0] != 11'h0) bq.push_back({32'h1001 + 32'(i), rows[i].ctl[10:0]});
            fq.push_back(rows[i].fwd);
            run({1'b1, rows[i].ctl[31]}, 32'h10);
            chk(tx_host_model_inst.mem[0], 32'h0, "owner");
        end
        // two-segment frame, slow far side, wrap to base
        slow <= 1'b1;
        put(1, 32'h8010_0002); put(2, 32'h2001); put(3, 32'h20);
        put(9, 32'h2200_0003); put(10, 32'h3002); put(11, 32'h40);
        put(8, 32'h8000_0000); put(0, 32'h8000_0000);
        bq.push_back({32'h2001, 11'h2});
        bq.push_back({32'h3002, 11'h3});
        fq.push_back(4'h0);
        axw(tx_desc_pkg::OFS_MASK, 32'h0);
        axw(tx_desc_pkg::OFS_MASK, 32'h2);
        run(2'h2, 32'h0);
        chk({tx_host_model_inst.mem[0], tx_host_model_inst.mem[8]}, 64'h0, "owners");
        wrap_up();
    end
    initial begin
        #100_000;
        fail_count++;
        wrap_up();
    end
endmodule : tx_descriptor_interpreter_tb_top

// ===== sim/tx_host_model.sv
// partner: descriptor memory, buffer mover and mac
// assumes one engine request up at a time, all on clk_i
`timescale 1ns/1ps
module tx_host_model (
    // clock, reset, pace
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        slow_i,
    // requests
    input  wire logic        mem_req_i,
    input  wire logic        mem_we_i,
    input  wire logic [31:0] mem_addr_i,
    input  wire logic [31:0] mem_wdata_i,
    input  wire logic        buf_req_i,
    input  wire logic        fwd_valid_i,
    // answers
    output logic             mem_ack_o,
    output logic [31:0]      mem_rdata_o,
    output logic             buf_done_o,
    output logic             tx_done_o
);
    // ****
    // behaviour
    // ****
    logic [31:0] mem [0:63];
    logic [3:0]  cnt;
    logic        go;
    // slow pace adds three waits per memory and buffer answer; tx_done_o is not paced
    assign go = (cnt == (slow_i ? 4'h3 : 4'h0)) && !mem_ack_o && !buf_done_o;
    always @(posedge clk_i) begin
        mem_ack_o <= mem_req_i && go && !rst_i;
        buf_done_o <= buf_req_i && go && !rst_i;
        tx_done_o <= fwd_valid_i && !rst_i;
        // wait count restarts after every answer, else fast pace would wrap the counter
        cnt <= (rst_i || go || mem_ack_o || buf_done_o || !(mem_req_i || buf_req_i)) ? 4'h0 : cnt + 4'h1;
        // idle data lines toggle so nothing stale passes for a word
        mem_rdata_o <= rst_i ? 32'h0 : (mem_req_i && go) ? mem[mem_addr_i[7:2]] : ~mem_rdata_o;
        if (mem_req_i && go && mem_we_i)
            mem[mem_addr_i[7:2]] <= mem_wdata_i;
    end
endmodule : tx_host_model
